//--- hw/gcr_regs.sv
// AXI4-Lite register bank holding per-channel gain selects and global chop settings
`timescale 1ns/1ps
`default_nettype none
`include "gcr_consts.svh"

module gcr_regs
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [2:0] ch0_gain_select,
    output logic [2:0] ch1_gain_select,
    output logic [2:0] ch2_gain_select,
    output logic [2:0] ch3_gain_select,
    output logic [31:0] ch_gain_factor,
    output logic chop_enable,
    output logic [3:0] chop_settle_delay,
    output logic [16:0] chop_settle_periods
);
    // Register storage
    logic [15:0] gain_reg;
    logic [15:0] gain_next;
    logic [15:0] rsva_reg;
    logic [15:0] rsva_next;
    logic [15:0] chop_reg;
    logic [15:0] chop_next;
    logic [15:0] rsvb_reg;
    logic [15:0] rsvb_next;
    logic [15:0] rsvc_reg;
    logic [15:0] rsvc_next;
    logic [7:0] upd_cnt_reg;
    logic [7:0] upd_cnt_next;

    // Write channel state
    logic aw_held_reg;
    logic aw_held_next;
    logic [7:0] aw_addr_reg;
    logic [7:0] aw_addr_next;
    logic w_held_reg;
    logic w_held_next;
    logic [31:0] w_data_reg;
    logic [31:0] w_data_next;
    logic [3:0] w_strb_reg;
    logic [3:0] w_strb_next;
    logic awready_reg;
    logic awready_next;
    logic wready_reg;
    logic wready_next;
    logic bvalid_reg;
    logic bvalid_next;
    logic [1:0] bresp_reg;
    logic [1:0] bresp_next;

    // Read channel state
    logic arready_reg;
    logic arready_next;
    logic rvalid_reg;
    logic rvalid_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [1:0] rresp_reg;
    logic [1:0] rresp_next;

    logic do_write;
    gcr_pkg::gcr_reg_sel_type wr_sel;
    gcr_pkg::gcr_reg_sel_type rd_sel;

    gcr_cfg_if cfg ();

    // Maps a byte address to a register; low two bits are ignored
    function automatic gcr_pkg::gcr_reg_sel_type decode_addr(input logic [7:0] addr);
        unique case (addr[7:2])
            `GCR_IDX_GAIN: decode_addr = gcr_pkg::GCR_SEL_GAIN;
            `GCR_IDX_RSVA: decode_addr = gcr_pkg::GCR_SEL_RSVA;
            `GCR_IDX_CHOP: decode_addr = gcr_pkg::GCR_SEL_CHOP;
            `GCR_IDX_RSVB: decode_addr = gcr_pkg::GCR_SEL_RSVB;
            `GCR_IDX_RSVC: decode_addr = gcr_pkg::GCR_SEL_RSVC;
            `GCR_IDX_STAT: decode_addr = gcr_pkg::GCR_SEL_STAT;
            default: decode_addr = gcr_pkg::GCR_SEL_NONE;
        endcase
    endfunction : decode_addr

    // Applies the two low byte lanes of a write to a 16-bit word
    function automatic logic [15:0] merge_lanes(input logic [15:0] old_word, input logic [31:0] data,
                                                input logic [3:0] strb);
        merge_lanes[7:0] = strb[0] ? data[7:0] : old_word[7:0];
        merge_lanes[15:8] = strb[1] ? data[15:8] : old_word[15:8];
    endfunction : merge_lanes

    assign wr_sel = decode_addr(aw_addr_reg);
    assign rd_sel = decode_addr(s_axi_araddr);
    assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;

    // Write path: address and data taken in either order, response after both
    always_comb
    begin
        aw_held_next = aw_held_reg;
        aw_addr_next = aw_addr_reg;
        w_held_next = w_held_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        gain_next = gain_reg;
        rsva_next = rsva_reg;
        chop_next = chop_reg;
        rsvb_next = rsvb_reg;
        rsvc_next = rsvc_reg;
        upd_cnt_next = upd_cnt_reg;
        if (s_axi_awvalid && awready_reg)
        begin
            aw_held_next = 1'b1;
            aw_addr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_reg)
        begin
            w_held_next = 1'b1;
            w_data_next = s_axi_wdata;
            w_strb_next = s_axi_wstrb;
        end
        if (bvalid_reg && s_axi_bready)
        begin
            bvalid_next = 1'b0;
        end
        if (do_write)
        begin
            aw_held_next = 1'b0;
            w_held_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = `GCR_RESP_OKAY;
            // Reserved writable bits are stored as written; software keeps them zero
            unique case (wr_sel)
                gcr_pkg::GCR_SEL_GAIN:
                begin
                    gain_next = merge_lanes(gain_reg, w_data_reg, w_strb_reg);
                    upd_cnt_next = upd_cnt_reg + 8'h01;
                end
                gcr_pkg::GCR_SEL_RSVA: rsva_next = merge_lanes(rsva_reg, w_data_reg, w_strb_reg);
                gcr_pkg::GCR_SEL_CHOP:
                begin
                    chop_next = merge_lanes(chop_reg, w_data_reg, w_strb_reg);
                    upd_cnt_next = upd_cnt_reg + 8'h01;
                end
                gcr_pkg::GCR_SEL_RSVB: rsvb_next = merge_lanes(rsvb_reg, w_data_reg, w_strb_reg);
                gcr_pkg::GCR_SEL_RSVC:
                    rsvc_next = merge_lanes(rsvc_reg, w_data_reg, w_strb_reg) & `GCR_RSVC_WMASK;
                gcr_pkg::GCR_SEL_STAT: bresp_next = `GCR_RESP_OKAY;
                gcr_pkg::GCR_SEL_NONE: bresp_next = `GCR_RESP_SLVERR;
            endcase
        end
        awready_next = !aw_held_next;
        wready_next = !w_held_next;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `GCR_RESP_OKAY;
            gain_reg <= `GCR_RST_GAIN;
            rsva_reg <= `GCR_RST_RSVA;
            chop_reg <= `GCR_RST_CHOP;
            rsvb_reg <= `GCR_RST_RSVB;
            rsvc_reg <= `GCR_RST_RSVC;
            upd_cnt_reg <= 8'h00;
        end
        else
        begin
            aw_held_reg <= aw_held_next;
            aw_addr_reg <= aw_addr_next;
            w_held_reg <= w_held_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            gain_reg <= gain_next;
            rsva_reg <= rsva_next;
            chop_reg <= chop_next;
            rsvb_reg <= rsvb_next;
            rsvc_reg <= rsvc_next;
            upd_cnt_reg <= upd_cnt_next;
        end
    end

    // Read path: one read at a time, data one cycle after the address is taken
    always_comb
    begin
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (rvalid_reg && s_axi_rready)
        begin
            rvalid_next = 1'b0;
        end
        if (s_axi_arvalid && arready_reg)
        begin
            rvalid_next = 1'b1;
            rresp_next = `GCR_RESP_OKAY;
            rdata_next = 32'h00000000;
            unique case (rd_sel)
                gcr_pkg::GCR_SEL_GAIN: rdata_next[15:0] = gain_reg;
                gcr_pkg::GCR_SEL_RSVA: rdata_next[15:0] = rsva_reg;
                gcr_pkg::GCR_SEL_CHOP: rdata_next[15:0] = chop_reg;
                gcr_pkg::GCR_SEL_RSVB: rdata_next[15:0] = rsvb_reg;
                gcr_pkg::GCR_SEL_RSVC: rdata_next[15:0] = rsvc_reg & `GCR_RSVC_WMASK;
                gcr_pkg::GCR_SEL_STAT:
                begin
                    rdata_next[`GCR_STAT_CNT] = upd_cnt_reg;
                    rdata_next[`GCR_STAT_EN] = chop_reg[`GCR_CHOP_EN];
                end
                gcr_pkg::GCR_SEL_NONE: rresp_next = `GCR_RESP_SLVERR;
            endcase
        end
        arready_next = !rvalid_next;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= `GCR_RESP_OKAY;
        end
        else
        begin
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    // Stored words feed the decoder, which registers the derived settings
    assign cfg.gain_word = gain_reg;
    assign cfg.chop_word = chop_reg;

    gcr_setting_decode u_decode
    (
        .clk(clk),
        .rst_n(rst_n),
        .cfg(cfg.sink),
        .gain_factor(ch_gain_factor),
        .settle_periods(chop_settle_periods)
    );

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // Settings drive the converter straight from the stored fields
    assign ch0_gain_select = gain_reg[`GCR_CH0_GAIN];
    assign ch1_gain_select = gain_reg[`GCR_CH1_GAIN];
    assign ch2_gain_select = gain_reg[`GCR_CH2_GAIN];
    assign ch3_gain_select = gain_reg[`GCR_CH3_GAIN];
    assign chop_enable = chop_reg[`GCR_CHOP_EN];
    assign chop_settle_delay = chop_reg[`GCR_CHOP_DLY];
endmodule : gcr_regs

`default_nettype wire

//--- hw/gcr_consts.svh
// Register indices, reset values, field positions and bus codes for the gain and chop register bank
`ifndef GCR_CONSTS_SVH
`define GCR_CONSTS_SVH

// Register indices; byte address is four times the index
`define GCR_IDX_GAIN 6'h04
`define GCR_IDX_RSVA 6'h05
`define GCR_IDX_CHOP 6'h06
`define GCR_IDX_RSVB 6'h07
`define GCR_IDX_RSVC 6'h08
`define GCR_IDX_STAT 6'h0F

// Reset values
`define GCR_RST_GAIN 16'h0000
`define GCR_RST_RSVA 16'h0000
`define GCR_RST_CHOP 16'h0600
`define GCR_RST_RSVB 16'h0000
`define GCR_RST_RSVC 16'h0000

// Gain register fields
`define GCR_CH3_GAIN 14:12
`define GCR_CH2_GAIN 10:8
`define GCR_CH1_GAIN 6:4
`define GCR_CH0_GAIN 2:0

// Chop configuration fields
`define GCR_CHOP_DLY 12:9
`define GCR_CHOP_EN 8

// Reserved word at 08h: bits 7:4 read as zero
`define GCR_RSVC_WMASK 16'hFF0F

// Status register fields
`define GCR_STAT_CNT 15:8
`define GCR_STAT_EN 0

// Delay codes with a special value
`define GCR_DLY_CODE_D 4'hD
`define GCR_DLY_CODE_E 4'hE
`define GCR_DLY_CODE_F 4'hF
`define GCR_DLY_VAL_D 17'h04000
`define GCR_DLY_VAL_E 17'h08000
`define GCR_DLY_VAL_F 17'h10000
`define GCR_DLY_BASE 17'h00002

// Decoded outputs while in reset: unity gain on all channels, 16 periods
`define GCR_RST_FACTOR 32'h01010101
`define GCR_RST_PERIODS 17'h00010

// AXI response codes
`define GCR_RESP_OKAY 2'h0
`define GCR_RESP_SLVERR 2'h2

`endif

//--- hw/gcr_pkg.sv
// Types shared by the gain and chop register bank
package gcr_pkg;

    typedef logic [2:0] gcr_gain_sel_type;
    typedef logic [3:0] gcr_dly_code_type;

    typedef enum logic [2:0]
    {
        GCR_SEL_NONE = 3'h0,
        GCR_SEL_GAIN = 3'h1,
        GCR_SEL_RSVA = 3'h2,
        GCR_SEL_CHOP = 3'h3,
        GCR_SEL_RSVB = 3'h4,
        GCR_SEL_RSVC = 3'h5,
        GCR_SEL_STAT = 3'h6
    } gcr_reg_sel_type;

endpackage : gcr_pkg

//--- hw/gcr_cfg_if.sv
// Carrier of the stored configuration words from the register file to the decoder
`timescale 1ns/1ps
`default_nettype none

interface gcr_cfg_if;
    logic [15:0] gain_word;
    logic [15:0] chop_word;

    modport source
    (
        output gain_word,
        output chop_word
    );

    modport sink
    (
        input gain_word,
        input chop_word
    );
endinterface : gcr_cfg_if

`default_nettype wire

//--- hw/gcr_setting_decode.sv
// Registered decode of gain selects into gain factors and delay code into modulator periods
`timescale 1ns/1ps
`default_nettype none
`include "gcr_consts.svh"

module gcr_setting_decode
(
    input wire logic clk,
    input wire logic rst_n,
    gcr_cfg_if.sink cfg,
    output logic [31:0] gain_factor,
    output logic [16:0] settle_periods
);
    logic [31:0] gain_factor_reg;
    logic [31:0] gain_factor_next;
    logic [16:0] settle_periods_reg;
    logic [16:0] settle_periods_next;

    // Gain is two to the power of the select
    function automatic logic [7:0] gain_of(input gcr_pkg::gcr_gain_sel_type sel);
        gain_of = 8'h01 << sel;
    endfunction : gain_of

    // Settle delay doubles per code from two periods; 1110b continues the doubling
    function automatic logic [16:0] periods_of(input gcr_pkg::gcr_dly_code_type code);
        unique case (code)
            `GCR_DLY_CODE_D: periods_of = `GCR_DLY_VAL_D;
            `GCR_DLY_CODE_E: periods_of = `GCR_DLY_VAL_E;
            `GCR_DLY_CODE_F: periods_of = `GCR_DLY_VAL_F;
            default: periods_of = `GCR_DLY_BASE << code;
        endcase
    endfunction : periods_of

    always_comb
    begin
        gain_factor_next = {gain_of(cfg.gain_word[`GCR_CH3_GAIN]), gain_of(cfg.gain_word[`GCR_CH2_GAIN]),
                            gain_of(cfg.gain_word[`GCR_CH1_GAIN]), gain_of(cfg.gain_word[`GCR_CH0_GAIN])};
        settle_periods_next = periods_of(cfg.chop_word[`GCR_CHOP_DLY]);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            gain_factor_reg <= `GCR_RST_FACTOR;
            settle_periods_reg <= `GCR_RST_PERIODS;
        end
        else
        begin
            gain_factor_reg <= gain_factor_next;
            settle_periods_reg <= settle_periods_next;
        end
    end

    assign gain_factor = gain_factor_reg;
    assign settle_periods = settle_periods_reg;
endmodule : gcr_setting_decode

`default_nettype wire

//--- test/gcr_regs_chk.sv
// Concurrent checks on the ports of the gain and chop register bank
`timescale 1ns/1ps
`default_nettype none
`include "gcr_consts.svh"

module gcr_regs_chk
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic [2:0] ch0_gain_select,
    input wire logic [2:0] ch1_gain_select,
    input wire logic [2:0] ch2_gain_select,
    input wire logic [2:0] ch3_gain_select,
    input wire logic [31:0] ch_gain_factor,
    input wire logic chop_enable,
    input wire logic [3:0] chop_settle_delay,
    input wire logic [16:0] chop_settle_periods
);
    logic [5:0] aw_idx_reg;
    logic [5:0] ar_idx_reg;
    logic [15:0] wd_reg;
    logic [1:0] ws_reg;

    function automatic logic [16:0] dly_val(input logic [3:0] code);
        dly_val = (code < 4'hD) ? (17'h00002 << code) : (code == 4'hD) ? 17'h04000
            : (code == 4'hE) ? 17'h08000 : 17'h10000;
    endfunction : dly_val

    // Remember the target and data of the transfer in flight
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            aw_idx_reg <= 6'h00;
            ar_idx_reg <= 6'h00;
            wd_reg <= 16'h0000;
            ws_reg <= 2'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
                aw_idx_reg <= s_axi_awaddr[7:2];
            if (s_axi_wvalid && s_axi_wready)
            begin
                wd_reg <= s_axi_wdata[15:0];
                ws_reg <= s_axi_wstrb[1:0];
            end
            if (s_axi_arvalid && s_axi_arready)
                ar_idx_reg <= s_axi_araddr[7:2];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_gain_factor;
        ch_gain_factor == {8'h01 << $past(ch3_gain_select), 8'h01 << $past(ch2_gain_select),
                           8'h01 << $past(ch1_gain_select), 8'h01 << $past(ch0_gain_select)};
    endproperty
    a_gain_factor: assert property (p_gain_factor) else $error("gain factor decode wrong");

    property p_settle;
        chop_settle_periods == dly_val($past(chop_settle_delay));
    endproperty
    a_settle: assert property (p_settle) else $error("settle delay decode wrong");

    property p_reset;
        $rose(rst_n) |-> chop_settle_delay == 4'h3 && !chop_enable && chop_settle_periods == 17'h00010
            && ch_gain_factor == 32'h01010101 && {ch3_gain_select, ch2_gain_select} == 6'h00;
    endproperty
    a_reset: assert property (p_reset) else $error("reset values wrong");

    property p_gain_wr;
        $rose(s_axi_bvalid) && aw_idx_reg == `GCR_IDX_GAIN && ws_reg == 2'h3
            |-> {ch3_gain_select, ch2_gain_select, ch1_gain_select, ch0_gain_select}
                == {wd_reg[14:12], wd_reg[10:8], wd_reg[6:4], wd_reg[2:0]};
    endproperty
    a_gain_wr: assert property (p_gain_wr) else $error("gain selects not applied");

    property p_chop_wr;
        $rose(s_axi_bvalid) && aw_idx_reg == `GCR_IDX_CHOP && ws_reg == 2'h3
            |-> {chop_settle_delay, chop_enable} == wd_reg[12:8];
    endproperty
    a_chop_wr: assert property (p_chop_wr) else $error("chop setting not applied");

    property p_gain_rd;
        $rose(s_axi_rvalid) && ar_idx_reg == `GCR_IDX_GAIN |-> {s_axi_rdata[14:12], s_axi_rdata[10:8],
            s_axi_rdata[6:4], s_axi_rdata[2:0]} == $past({ch3_gain_select, ch2_gain_select, ch1_gain_select,
            ch0_gain_select});
    endproperty
    a_gain_rd: assert property (p_gain_rd) else $error("gain read data wrong");

    property p_chop_rd;
        $rose(s_axi_rvalid) && ar_idx_reg == `GCR_IDX_CHOP
            |-> s_axi_rdata[12:8] == $past({chop_settle_delay, chop_enable});
    endproperty
    a_chop_rd: assert property (p_chop_rd) else $error("chop read data wrong");

    property p_rsvc_rd;
        $rose(s_axi_rvalid) && ar_idx_reg == `GCR_IDX_RSVC |-> s_axi_rdata[7:4] == 4'h0;
    endproperty
    a_rsvc_rd: assert property (p_rsvc_rd) else $error("read-only bits not zero");
endmodule : gcr_regs_chk

bind gcr_regs gcr_regs_chk u_chk (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .ch0_gain_select, .ch1_gain_select, .ch2_gain_select, .ch3_gain_select,
    .ch_gain_factor, .chop_enable, .chop_settle_delay, .chop_settle_periods);

`default_nettype wire

//--- test/gcr_host_model.sv
// Host controller model issuing register accesses
`timescale 1ns/1ps
`default_nettype none

module gcr_host_model
(
    input wire logic clk,
    output logic [7:0] s_axi_awaddr,
    output logic [2:0] s_axi_awprot,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic [2:0] s_axi_arprot,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    initial
    begin
        {s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_araddr, s_axi_arprot, s_axi_arvalid} = '0;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
    end

    // Bits the host may set; reserved bits go out as zero, except bits 7:4 of the reserved word at 08h, which pass through
    function automatic logic [15:0] legal_bits(input logic [5:0] idx);
        case (idx)
            6'h04: legal_bits = 16'h7777;
            6'h05, 6'h07: legal_bits = 16'h0000;
            6'h06: legal_bits = 16'h1F00;
            6'h08: legal_bits = 16'h00F0;
            default: legal_bits = 16'hFFFF;
        endcase
    endfunction : legal_bits

    task automatic wr_reg(input logic [7:0] addr, input logic [15:0] data, input logic [3:0] strb,
                          output logic [1:0] resp);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        s_axi_awaddr <= addr;
        s_axi_wdata <= {16'h0000, data & legal_bits(addr[7:2])};
        s_axi_wstrb <= strb;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_done && w_done))
        begin
            @(posedge clk);
            if (!aw_done && s_axi_awready)
            begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready)
            begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do
            @(posedge clk);
        while (!s_axi_bvalid);
        resp = s_axi_bresp;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] addr, output logic [31:0] data, output logic [1:0] resp);
        s_axi_araddr <= addr;
        s_axi_arvalid <= 1'b1;
        do
            @(posedge clk);
        while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do
            @(posedge clk);
        while (!s_axi_rvalid);
        data = s_axi_rdata;
        resp = s_axi_rresp;
    endtask : rd_reg
endmodule : gcr_host_model

`default_nettype wire

//--- test/gain_and_chop_config_regs_test.sv
// Self-checking testbench of the gain and chop register bank
`timescale 1ns/1ps
`default_nettype none

module gain_and_chop_config_regs_test;
    logic clk;
    logic rst_n;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, chop_enable;
    logic [31:0] s_axi_wdata, s_axi_rdata, ch_gain_factor;
    logic [3:0] s_axi_wstrb, chop_settle_delay;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [2:0] ch0_gain_select, ch1_gain_select, ch2_gain_select, ch3_gain_select;
    logic [16:0] chop_settle_periods;
    logic [31:0] rd;
    logic [15:0] gw, cw;
    logic [7:0] addr_tab[5] = '{8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
    logic [15:0] rst_tab[5] = '{16'h0000, 16'h0000, 16'h0600, 16'h0000, 16'h0000};
    int n_fail = 0;
    int check_count = 0;

    gcr_regs dut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .ch0_gain_select, .ch1_gain_select, .ch2_gain_select, .ch3_gain_select, .ch_gain_factor, .chop_enable,
        .chop_settle_delay, .chop_settle_periods);

    gcr_host_model u_host (.clk, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    function automatic logic [16:0] dly_val(input logic [3:0] code);
        dly_val = (code < 4'hD) ? (17'h00002 << code) : (code == 4'hD) ? 17'h04000
            : (code == 4'hE) ? 17'h08000 : 17'h10000;
    endfunction : dly_val

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run

    initial
    begin
        clk = 1'b0;
        forever
            #2 clk = ~clk;
    end

    initial
    begin
        #40000;
        n_fail++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        complete_run;
    end

    initial
    begin
        rst_n = 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 5; i++)
        begin
            u_host.rd_reg(addr_tab[i], rd, rs);
            chk({14'h0, rs, rd[15:0]}, {16'h0000, rst_tab[i]}, "reset value");
        end
        chk({15'h0, chop_settle_periods}, 32'h00000010, "reset settle");
        $display("Test reset values done");
        for (int c = 0; c < 8; c++)
        begin
            gw = {1'b0, 3'(c + 3), 1'b0, 3'(c + 2), 1'b0, 3'(c + 1), 1'b0, 3'(c)};
            u_host.wr_reg(8'h10, gw, 4'hF, rs);
            u_host.rd_reg(8'h10, rd, rs);
            chk(rd, {16'h0000, gw}, "gain readback");
            chk({20'h0, ch3_gain_select, ch2_gain_select, ch1_gain_select, ch0_gain_select},
                {20'h0, gw[14:12], gw[10:8], gw[6:4], gw[2:0]}, "gain pins");
            chk(ch_gain_factor, {8'h01 << gw[14:12], 8'h01 << gw[10:8], 8'h01 << gw[6:4], 8'h01 << gw[2:0]},
                "gain factor");
        end
        u_host.wr_reg(8'h10, 16'h7777, 4'h1, rs);
        u_host.rd_reg(8'h10, rd, rs);
        chk(rd, {16'h0000, gw[15:8], 8'h77}, "low lane write");
        $display("Test gain selects done");
        for (int c = 0; c < 16; c++)
        begin
            cw = {3'h0, 4'(c), 1'(c), 8'h00};
            u_host.wr_reg(8'h18, cw, 4'hF, rs);
            u_host.rd_reg(8'h18, rd, rs);
            chk(rd, {16'h0000, cw}, "chop readback");
            chk({27'h0, chop_settle_delay, chop_enable}, {27'h0, cw[12:8]}, "chop pins");
            chk({15'h0, chop_settle_periods}, {15'h0, dly_val(cw[12:9])}, "settle periods");
        end
        $display("Test chop settings done");
        u_host.wr_reg(8'h20, 16'h00F0, 4'hF, rs);
        u_host.rd_reg(8'h20, rd, rs);
        chk(rd, 32'h00000000, "read-only bits");
        u_host.wr_reg(8'h00, 16'h1234, 4'hF, rs);
        chk({30'h0, rs}, 32'h00000002, "unmapped write response");
        u_host.rd_reg(8'h00, rd, rs);
        chk({14'h0, rs, rd[15:0]}, 32'h00020000, "unmapped read");
        u_host.rd_reg(8'h18, rd, rs);
        chk(rd, {16'h0000, cw}, "chop kept after unmapped write");
        // Status: 9 gain and 16 chop writes committed, chop left enabled; writes to it are ignored
        u_host.wr_reg(8'h3C, 16'hFFFF, 4'hF, rs);
        chk({30'h0, rs}, 32'h00000000, "status write response");
        u_host.rd_reg(8'h3C, rd, rs);
        chk({14'h0, rs, rd[15:0]}, 32'h00001901, "status count and enable");
        $display("Test reserved and unmapped done");
        complete_run;
    end
endmodule : gain_and_chop_config_regs_test

`default_nettype wire
